// [hw/aqc_pkg.sv]
/*
 Package for the analog quad configuration decoder: register offsets,
 field positions, reset values and mux encodings.
 Assumes nothing of its surroundings.
*/
package aqc_pkg;
	// register byte addresses on the APB bus
	localparam logic [3:0] OFF_VOLTAGE = 4'h0;
	localparam logic [3:0] OFF_CURRENT = 4'h4;
	localparam logic [3:0] OFF_GATE = 4'h8;
	localparam logic [3:0] OFF_TEMP = 4'hC;
	// analog input channel byte fields
	localparam int SCALE_LSB = 0;
	localparam int SCALE_MSB = 2;
	localparam int MUX_LSB = 3;
	localparam int MUX_MSB = 4;
	localparam int CURMON_BIT = 4;
	localparam int DIRECT_BIT = 5;
	localparam int POLARITY_BIT = 6;
	localparam int PRESCALER_BIT = 7;
	// gate driver byte fields
	localparam int TMON_BIT = 0;
	localparam int DRIVE_LSB = 2;
	localparam int DRIVE_MSB = 3;
	localparam int GATE_POL_BIT = 6;
	localparam int HIGH_DRIVE_BIT = 7;
	// gate driver byte bits that exist; spares read as zero
	localparam logic [7:0] GATE_MASK = 8'hCD;
	// temperature byte: polarity bit has no function, reads zero
	localparam logic [7:0] TEMP_MASK = 8'hBF;
	// power-up defaults: 16 V range, prescaler path, all off
	localparam logic [7:0] RST_CHANNEL = 8'h00;
	localparam logic [7:0] RST_GATE = 8'h00;
	// mux routing codes
	typedef enum logic [1:0] {
		MUX_PRESCALER = 2'b00,
		MUX_DIRECT = 2'b01,
		MUX_MONITOR = 2'b10,
		MUX_INVALID = 2'b11
	} aqc_mux_t;
endpackage

// [hw/aqc_channel_decode.sv]
/*
 One analog input channel: decodes a configuration byte into the
 switch, mux, polarity and prescaler control lines, all registered.
 Assumes a byte held stable by the register bank.
*/
`timescale 1ns/1ps
`default_nettype none
module aqc_channel_decode (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// configuration byte
	input wire logic [7:0] cfgByte,
	// decoded controls
	output logic [2:0] scaleSel,
	output logic adcFromPrescaler,
	output logic adcFromDirect,
	output logic adcFromMonitor,
	output logic directSwitchOn,
	output logic polarityNegative,
	output logic prescalerOn
);
	aqc_pkg::aqc_mux_t muxCode;
	assign muxCode = aqc_pkg::aqc_mux_t'(cfgByte[aqc_pkg::MUX_MSB:aqc_pkg::MUX_LSB]);

	// mux decode; invalid code routes nothing so two sources never short
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			adcFromPrescaler <= 1'b1;
			adcFromDirect <= 1'b0;
			adcFromMonitor <= 1'b0;
		end else begin
			unique case (muxCode)
				aqc_pkg::MUX_PRESCALER: begin
					adcFromPrescaler <= 1'b1;
					adcFromDirect <= 1'b0;
					adcFromMonitor <= 1'b0;
				end
				aqc_pkg::MUX_DIRECT: begin
					adcFromPrescaler <= 1'b0;
					adcFromDirect <= 1'b1;
					adcFromMonitor <= 1'b0;
				end
				aqc_pkg::MUX_MONITOR: begin
					adcFromPrescaler <= 1'b0;
					adcFromDirect <= 1'b0;
					adcFromMonitor <= 1'b1;
				end
				aqc_pkg::MUX_INVALID: begin
					adcFromPrescaler <= 1'b0;
					adcFromDirect <= 1'b0;
					adcFromMonitor <= 1'b0;
				end
			endcase
		end
	end

	// remaining per-channel controls
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			scaleSel <= 3'h0;
			directSwitchOn <= 1'b0;
			polarityNegative <= 1'b0;
			prescalerOn <= 1'b0;
		end else begin
			scaleSel <= cfgByte[aqc_pkg::SCALE_MSB:aqc_pkg::SCALE_LSB];
			directSwitchOn <= cfgByte[aqc_pkg::DIRECT_BIT];
			polarityNegative <= cfgByte[aqc_pkg::POLARITY_BIT];
			prescalerOn <= cfgByte[aqc_pkg::PRESCALER_BIT];
		end
	end
endmodule
`default_nettype wire

// [hw/aqc_quad_config.sv]
/*
 Analog quad configuration register bank with APB slave and decoders
 for the voltage, current and temperature channels and gate driver.
 Assumes an APB master on core_clk and a synchronous gate-drive-on input.
*/
// The address map and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module aqc_quad_config (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// gate driver enable from fabric
	input wire logic gate_drive_on_input,
	// voltage channel controls
	output logic [2:0] voltageScale,
	output logic voltageAdcFromPrescaler,
	output logic voltageAdcFromDirect,
	output logic voltageAdcFromMonitor,
	output logic voltageDirectOn,
	output logic voltagePolarityNeg,
	output logic voltagePrescalerOn,
	output logic currentMonitorSwitchOn,
	// current channel controls
	output logic [2:0] currentScale,
	output logic currentAdcFromPrescaler,
	output logic currentAdcFromDirect,
	output logic currentAdcFromMonitor,
	output logic currentDirectOn,
	output logic currentPolarityNeg,
	output logic currentPrescalerOn,
	// temperature channel controls
	output logic [2:0] tempScale,
	output logic tempAdcFromPrescaler,
	output logic tempAdcFromDirect,
	output logic tempAdcFromMonitor,
	output logic tempDirectOn,
	output logic tempPolarityNeg,
	output logic tempPrescalerOn,
	// gate driver controls
	output logic [1:0] gateLowCurrentSel,
	output logic gatePolarityNeg,
	output logic gateLowDriveOn,
	output logic gateHighDriveOn,
	output logic temp_monitor_power_ctl
);
	logic [7:0] voltage_channel_config;
	logic [7:0] current_channel_config;
	logic [7:0] gate_driver_config;
	logic [7:0] temperature_channel_config;
	logic access;
	logic wrStrobe;
	logic addrHit;
	logic [3:0] regAddr;
	logic [7:0] next_readByte;

	assign regAddr = paddr[3:0];
	assign access = psel && penable;
	assign wrStrobe = access && pwrite && pstrb[0] && addrHit;
	assign addrHit = (paddr[31:4] == 28'h0000000) &&
		(regAddr == aqc_pkg::OFF_VOLTAGE || regAddr == aqc_pkg::OFF_CURRENT ||
		regAddr == aqc_pkg::OFF_GATE || regAddr == aqc_pkg::OFF_TEMP);

	// register writes; bytes keep power-up defaults until written
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			voltage_channel_config <= aqc_pkg::RST_CHANNEL;
			current_channel_config <= aqc_pkg::RST_CHANNEL;
			gate_driver_config <= aqc_pkg::RST_GATE;
			temperature_channel_config <= aqc_pkg::RST_CHANNEL;
		end else if (wrStrobe) begin
			unique case (regAddr)
				aqc_pkg::OFF_VOLTAGE: voltage_channel_config <= pwdata[7:0];
				aqc_pkg::OFF_CURRENT: current_channel_config <= pwdata[7:0];
				aqc_pkg::OFF_GATE: gate_driver_config <= pwdata[7:0] & aqc_pkg::GATE_MASK;
				// polarity bit forced zero: pad only takes positive input
				aqc_pkg::OFF_TEMP: begin
					temperature_channel_config <= pwdata[7:0] & aqc_pkg::TEMP_MASK;
				end
				default: begin
				end
			endcase
		end
	end

	// read mux for the addressed byte
	always_comb begin
		next_readByte = 8'h00;
		unique case (regAddr)
			aqc_pkg::OFF_VOLTAGE: next_readByte = voltage_channel_config;
			aqc_pkg::OFF_CURRENT: next_readByte = current_channel_config;
			aqc_pkg::OFF_GATE: next_readByte = gate_driver_config;
			aqc_pkg::OFF_TEMP: next_readByte = temperature_channel_config;
			default: next_readByte = 8'h00;
		endcase
	end

	// apb answer: no wait state, ready registered off the setup phase so outputs stay registered
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
		end else if (psel && !penable) begin
			pready <= 1'b1;
			pslverr <= !addrHit;
			prdata <= {24'h000000, addrHit ? next_readByte : 8'h00};
		end else begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
		end
	end

	// voltage channel decode
	aqc_channel_decode uVoltage (
		.core_clk(core_clk),
		.rst(rst),
		.cfgByte(voltage_channel_config),
		.scaleSel(voltageScale),
		.adcFromPrescaler(voltageAdcFromPrescaler),
		.adcFromDirect(voltageAdcFromDirect),
		.adcFromMonitor(voltageAdcFromMonitor),
		.directSwitchOn(voltageDirectOn),
		.polarityNegative(voltagePolarityNeg),
		.prescalerOn(voltagePrescalerOn)
	);

	// current channel decode
	aqc_channel_decode uCurrent (
		.core_clk(core_clk),
		.rst(rst),
		.cfgByte(current_channel_config),
		.scaleSel(currentScale),
		.adcFromPrescaler(currentAdcFromPrescaler),
		.adcFromDirect(currentAdcFromDirect),
		.adcFromMonitor(currentAdcFromMonitor),
		.directSwitchOn(currentDirectOn),
		.polarityNegative(currentPolarityNeg),
		.prescalerOn(currentPrescalerOn)
	);

	// temperature channel; range limits left to software
	aqc_channel_decode uTemp (
		.core_clk(core_clk),
		.rst(rst),
		.cfgByte(temperature_channel_config),
		.scaleSel(tempScale),
		.adcFromPrescaler(tempAdcFromPrescaler),
		.adcFromDirect(tempAdcFromDirect),
		.adcFromMonitor(tempAdcFromMonitor),
		.directSwitchOn(tempDirectOn),
		.polarityNegative(tempPolarityNeg),
		.prescalerOn(tempPrescalerOn)
	);

	// current monitor switch lives in the voltage byte
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			currentMonitorSwitchOn <= 1'b0;
		end else begin
			currentMonitorSwitchOn <= voltage_channel_config[aqc_pkg::CURMON_BIT];
		end
	end

	// gate driver; enable input gates both drive modes
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			gateLowCurrentSel <= 2'h0;
			gatePolarityNeg <= 1'b0;
			gateLowDriveOn <= 1'b0;
			gateHighDriveOn <= 1'b0;
			temp_monitor_power_ctl <= 1'b0;
		end else begin
			gateLowCurrentSel <= gate_driver_config[aqc_pkg::DRIVE_MSB:aqc_pkg::DRIVE_LSB];
			gatePolarityNeg <= gate_driver_config[aqc_pkg::GATE_POL_BIT];
			gateLowDriveOn <= gate_drive_on_input &&
				!gate_driver_config[aqc_pkg::HIGH_DRIVE_BIT];
			gateHighDriveOn <= gate_drive_on_input &&
				gate_driver_config[aqc_pkg::HIGH_DRIVE_BIT];
			temp_monitor_power_ctl <= gate_driver_config[aqc_pkg::TMON_BIT];
		end
	end
endmodule
`default_nettype wire

// [tb/aqc_quad_config_checker.sv]
/*
 Checker for the quad config bank: apb timing and decoded outputs.
 Bound to aqc_quad_config; sees its ports only.
*/
`timescale 1ns/1ps
`default_nettype none
module aqc_quad_config_checker (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// gate enable input and decoded controls
	input wire logic gate_drive_on_input,
	input wire logic voltageAdcFromPrescaler,
	input wire logic voltageAdcFromDirect,
	input wire logic voltageAdcFromMonitor,
	input wire logic tempPolarityNeg,
	input wire logic [1:0] gateLowCurrentSel,
	input wire logic gatePolarityNeg,
	input wire logic gateLowDriveOn,
	input wire logic gateHighDriveOn,
	input wire logic temp_monitor_power_ctl
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	// gate byte write commits on this edge
	wire logic gateWr = psel && penable && pready && pwrite && pstrb[0]
		&& paddr == {28'h0, aqc_pkg::OFF_GATE};
	a_setup_ready: assert property (psel && !penable |=> pready)
		else $error("no ready after setup");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("ready held too long");
	a_err_ready: assert property (pslverr |-> pready)
		else $error("error without ready");
	a_idle_rdata: assert property (!pready |-> prdata == 32'h0)
		else $error("read data outside access");
	a_mux_single: assert property ($onehot0({voltageAdcFromPrescaler,
		voltageAdcFromDirect, voltageAdcFromMonitor})) else $error("two sources on adc");
	a_drive_gated: assert property (!$past(gate_drive_on_input) |->
		!gateLowDriveOn && !gateHighDriveOn) else $error("drive without enable");
	a_drive_mode: assert property (!$past(rst) && $past(gate_drive_on_input) |->
		gateLowDriveOn ^ gateHighDriveOn) else $error("drive mode not single");
	a_temp_pol: assert property (!tempPolarityNeg)
		else $error("temperature polarity negative");
	a_gate_decode: assert property (gateWr |=> ##1
		temp_monitor_power_ctl == $past(pwdata[0], 2) && gatePolarityNeg == $past(pwdata[6], 2)
		&& gateLowCurrentSel == $past(pwdata[3:2], 2)) else $error("gate decode wrong");
	c_gate_write: cover property (gateWr);
	c_high_drive: cover property (gateHighDriveOn);
	c_slave_err: cover property (pslverr);
endmodule
bind aqc_quad_config aqc_quad_config_checker chk (.core_clk, .rst, .psel, .penable, .pwrite,
	.paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .gate_drive_on_input,
	.voltageAdcFromPrescaler, .voltageAdcFromDirect, .voltageAdcFromMonitor, .tempPolarityNeg,
	.gateLowCurrentSel, .gatePolarityNeg, .gateLowDriveOn, .gateHighDriveOn,
	.temp_monitor_power_ctl);
`default_nettype wire

// [tb/aqc_cfg_master.sv]
/*
 Apb master model in place of the configuration state machine.
 Assumes one caller at a time, entering just after a clock edge.
*/
`timescale 1ns/1ps
`default_nettype none
module aqc_cfg_master (
	// clock
	input wire logic core_clk,
	// apb request
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [31:0] paddr,
	output logic [31:0] pwdata,
	output logic [3:0] pstrb,
	// apb answer
	input wire logic pready
);
	initial begin
		{psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
	end
	// one transfer; gap idles first so quick and slow pacing both occur
	task automatic xfer(input logic w, input logic [31:0] a, input logic [7:0] d,
		input int gap, output logic to);
		int n;
		repeat (gap + 1) @(posedge core_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		pstrb <= 4'hF;
		@(posedge core_clk);
		penable <= 1'b1;
		n = 0;
		// request held until ready is seen at an edge
		do begin
			@(posedge core_clk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		to = pready !== 1'b1;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
endmodule
`default_nettype wire

// [tb/testbench.sv]
/*
 Self-checking bench for the quad config bank.
 Drives apb through the master model; reads checked from a note queue.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin err_count++; \
	$display("[FAIL] %0t got %h want %h", $time, a, b); end end
module testbench;
	logic core_clk, rst, gateDriveOn, psel, penable, pwrite, pready, pslverr, curMon, to;
	logic [31:0] paddr, pwdata, prdata;
	logic [3:0] pstrb;
	// nets, since each bit group is driven by its own output port
	wire logic [8:0] vOut, cOut, tOut;
	wire logic [5:0] gOut;
	logic [32:0] expQ[$];
	logic [32:0] note;
	logic [7:0] sh[4];
	logic [7:0] b;
	int err_count = 0, check_count = 0, seed = 11147, idx;
	always #5 core_clk = ~core_clk;
	aqc_cfg_master mst (.core_clk, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .pready);
	aqc_quad_config uut (.core_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
		.prdata, .pready, .pslverr, .gate_drive_on_input(gateDriveOn),
		.voltageScale(vOut[8:6]), .voltageAdcFromPrescaler(vOut[5]),
		.voltageAdcFromDirect(vOut[4]), .voltageAdcFromMonitor(vOut[3]),
		.voltageDirectOn(vOut[2]), .voltagePolarityNeg(vOut[1]), .voltagePrescalerOn(vOut[0]),
		.currentMonitorSwitchOn(curMon), .currentScale(cOut[8:6]),
		.currentAdcFromPrescaler(cOut[5]), .currentAdcFromDirect(cOut[4]),
		.currentAdcFromMonitor(cOut[3]), .currentDirectOn(cOut[2]),
		.currentPolarityNeg(cOut[1]), .currentPrescalerOn(cOut[0]), .tempScale(tOut[8:6]),
		.tempAdcFromPrescaler(tOut[5]), .tempAdcFromDirect(tOut[4]),
		.tempAdcFromMonitor(tOut[3]), .tempDirectOn(tOut[2]), .tempPolarityNeg(tOut[1]),
		.tempPrescalerOn(tOut[0]), .gateLowCurrentSel(gOut[5:4]), .gatePolarityNeg(gOut[3]),
		.gateLowDriveOn(gOut[2]), .gateHighDriveOn(gOut[1]), .temp_monitor_power_ctl(gOut[0]));
	// expected channel lines; code 11 routes nothing
	function automatic logic [8:0] chexp(input logic [7:0] c);
		return {c[2:0], c[4:3] == 2'd0, c[4:3] == 2'd1, c[4:3] == 2'd2, c[5], c[6], c[7]};
	endfunction
	task give_verdict;
		$display("errors %0d checks %0d", err_count, check_count);
		if (err_count == 0 && check_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// monitor: oldest note per finished transfer
	always @(posedge core_clk) begin
		if (!rst && psel && penable && pready === 1'b1) begin
			note = expQ.size() ? expQ.pop_front() : 33'h1_DEAD_BEEF;
			`CHK(pslverr, note[32])
			if (!pwrite) `CHK(prdata, note[31:0])
		end
	end
	task automatic bus(input logic w, input logic [31:0] a, input logic [7:0] d, input logic [32:0] e);
		expQ.push_back(e);
		mst.xfer(w, a, d, {$random(seed)} % 3, to);
		if (to) begin
			err_count++;
			give_verdict();
		end
	endtask
	// outputs settle one edge after the commit edge; two are waited
	task automatic check_outs;
		repeat (2) @(posedge core_clk);
		#1;
		`CHK(vOut, chexp(sh[0]))
		`CHK(cOut, chexp(sh[1]))
		`CHK(tOut, chexp(sh[3]))
		`CHK(curMon, sh[0][4])
		`CHK(gOut, {sh[2][3:2], sh[2][6], gateDriveOn & ~sh[2][7], gateDriveOn & sh[2][7], sh[2][0]})
	endtask
	initial begin
		core_clk = 0;
		rst = 1;
		gateDriveOn = 0;
		sh = '{default: 8'h00};
		repeat (12) @(posedge core_clk);
		rst <= 1'b0;
		for (int k = 0; k < 4; k++) bus(1'b0, 32'(4 * k), 8'h00, 33'h0);
		check_outs();
		// every mux and drive code per register, random rest except temperature bits 0, 2 and 6 held zero
		for (int i = 0; i < 64; i++) begin
			idx = i % 4;
			b = 8'($random(seed));
			b[4:3] = 2'(i >> 2);
			if (idx == 2) b[3:2] = 2'(i >> 2);
			if (idx == 3) b = b & 8'hBA;
			@(posedge core_clk) gateDriveOn <= 1'($random(seed));
			bus(1'b1, 32'(4 * idx), b, 33'h0);
			sh[idx] = idx == 2 ? b & aqc_pkg::GATE_MASK : b;
			bus(1'b0, 32'(4 * idx), 8'h00, {25'h0, sh[idx]});
			if (i % 8 == 7) bus(1'b1, 32'h10 + 32'(i), b, {1'b1, 32'h0});
			check_outs();
		end
		// reset in mid-run brings defaults back
		@(posedge core_clk) rst <= 1'b1;
		repeat (3) @(posedge core_clk);
		rst <= 1'b0;
		sh = '{default: 8'h00};
		check_outs();
		// readback of defaults, then an unmapped read that must error and return zero
		for (int k = 0; k < 4; k++) bus(1'b0, 32'(4 * k), 8'h00, 33'h0);
		bus(1'b0, 32'h00000020, 8'h00, {1'b1, 32'h0});
		give_verdict();
	end
endmodule
`default_nettype wire
